// file: src/iin_pkg.sv
// Package for the interrupt input and non-maskable interrupt block.
// Assumes a single 50 MHz clock and a plain register port with 8-bit offsets.
package iin_pkg;
  localparam int NUM_LINES = 16;
  localparam int CLK_MHZ = 50;
  localparam logic [7:0] OFF_EDGE_LEVEL_LO = 8'h00;
  localparam logic [7:0] OFF_EDGE_LEVEL_HI = 8'h01;
  localparam logic [7:0] OFF_MASK_LO = 8'h02;
  localparam logic [7:0] OFF_MASK_HI = 8'h03;
  localparam logic [7:0] OFF_PENDING_LO = 8'h04;
  localparam logic [7:0] OFF_PENDING_HI = 8'h05;
  localparam logic [7:0] OFF_ACK = 8'h06;
  localparam logic [7:0] OFF_EOI = 8'h07;
  localparam logic [7:0] OFF_NMI_CTRL = 8'h08;
  localparam logic [7:0] OFF_NMI_MASK = 8'h09;
  localparam logic [7:0] OFF_KBD_DATA = 8'h60;
  localparam int LINE_EIGHT = 8;
  localparam int LINE_KBD = 1;
  localparam int LINE_SPURIOUS = 7;
  localparam logic [7:0] VECTOR_BASE = 8'h08;
  localparam int NMI_SERR_EN_BIT = 2;
  localparam int NMI_CHK_EN_BIT = 3;
  localparam int NMI_CHK_STS_BIT = 6;
  localparam int NMI_SERR_STS_BIT = 7;
  localparam logic [7:0] NMI_CTRL_RESET = 8'h00;
  localparam logic NMI_MASK_RESET = 1'b0;
  localparam logic [15:0] EDGE_LEVEL_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hffff;
  localparam logic [15:0] LINES_PRESENT = 16'hcefa;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iin_bus_t;

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] prevLevel;
    logic [15:0] edgeLevel;
    logic [15:0] mask;
    logic [15:0] request;
    logic [15:0] inService;
    logic kbdLatch;
    logic [1:0] nmiSrcSync1;
    logic [1:0] nmiSrcSync2;
    logic [1:0] nmiStatus;
    logic [1:0] nmiSrcDisable;
    logic nmiMask;
    logic nmiOut;
    logic intOut;
    logic [7:0] rdata;
  } iin_state_t;
endpackage

// file: src/iin_irq_nmi.sv
// Interrupt request conditioning, a small priority resolver and NMI generation.
// Assumes request and NMI source pins are asynchronous and a one-cycle strobe register port.
// Notes on behaviour
// RULE1: Software selects edge or level per line.
// RULE2: Reset returns all lines to edge mode.
// RULE3: Source holds request until acknowledge.
// RULE4: Request gone at acknowledge gives line seven.
// RULE5: Keyboard rising edge latched, cleared reading 60h.
// RULE6: Line eight request is active low.
// RULE7: Interrupt output high while request pending, reset low.
// RULE8: Software programs controller after every reset.
// RULE9: System error or channel check raises NMI.
// RULE10: NMI signalled by rising output edge.
// RULE11: Handler reads status, then clears it.
// RULE12: Setting source disable bit clears pending NMI.
// RULE13: NMI only with both disables and mask zero.
// RULE14: Reset drives NMI output low.
// RULE15: Request inputs pass two synchroniser stages.
//
// The plain strobed port and the register offsets are this design's own decisions.
module iin_irq_nmi (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] irqLines,
  input wire logic requestLineEightN,
  input wire logic sysErrorN,
  input wire logic channelCheckN,
  input wire iin_pkg::iin_bus_t bus,
  output logic [7:0] rdata,
  output logic intOut,
  output logic nmiOut
);
  iin_pkg::iin_state_t st;
  iin_pkg::iin_state_t next_st;

  // Highest priority is the lowest numbered line, as on a classic resolver.
  function automatic logic [3:0] pickLine(input logic [15:0] req);
    logic [3:0] idx;
    idx = 4'(iin_pkg::LINE_SPURIOUS);
    for (int i = iin_pkg::NUM_LINES - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic isAddr(input iin_pkg::iin_bus_t b, input logic [7:0] off);
    return b.addr == off;
  endfunction

  logic [15:0] rawActive;
  always_comb begin
    rawActive = irqLines & iin_pkg::LINES_PRESENT;
    // RULE6: line eight inverted
    rawActive[iin_pkg::LINE_EIGHT] = ~requestLineEightN;
  end

  logic [15:0] lineLevel;
  logic [15:0] rising;
  logic [15:0] serviceable;
  logic [15:0] ackOneHot;
  logic [3:0] ackLine;
  logic [3:0] eoiLine;
  logic [15:0] eoiOneHot;
  logic [1:0] nmiActive;
  logic [1:0] nmiRise;
  logic nmiEnabled;

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // RULE15: two-stage synchroniser
    next_st.sync1 = rawActive;
    next_st.sync2 = st.sync1;
    next_st.prevLevel = st.sync2;
    next_st.nmiSrcSync1 = {~sysErrorN, ~channelCheckN};
    next_st.nmiSrcSync2 = st.nmiSrcSync1;
    lineLevel = st.sync2;
    rising = st.sync2 & ~st.prevLevel;
    // RULE5: keyboard edge latch
    if (rising[iin_pkg::LINE_KBD]) begin
      next_st.kbdLatch = 1'b1;
    end else if (bus.rd && isAddr(bus, iin_pkg::OFF_KBD_DATA)) begin
      next_st.kbdLatch = 1'b0;
    end
    lineLevel[iin_pkg::LINE_KBD] = st.sync2[iin_pkg::LINE_KBD] | st.kbdLatch;
    // RULE1: per-line edge or level
    for (int i = 0; i < iin_pkg::NUM_LINES; i++) begin
      if (st.edgeLevel[i]) begin
        next_st.request[i] = lineLevel[i];
      end else if (rising[i]) begin
        // The keyboard latch only holds the level; re-raising from it would repeat the request.
        next_st.request[i] = 1'b1;
      end else if (!lineLevel[i]) begin
        // A request withdrawn before acknowledge is dropped.
        next_st.request[i] = 1'b0;
      end
    end
    serviceable = st.request & ~st.mask & ~st.inService;
    ackLine = pickLine(serviceable);
    ackOneHot = 16'h0000;
    eoiLine = bus.wdata[3:0];
    eoiOneHot = 16'h0000;
    eoiOneHot[eoiLine] = 1'b1;
    if (bus.rd && isAddr(bus, iin_pkg::OFF_ACK)) begin
      // RULE4: spurious default vector
      if (serviceable != 16'h0000) begin
        ackOneHot[ackLine] = 1'b1;
        next_st.inService = st.inService | ackOneHot;
        next_st.request = next_st.request & ~(ackOneHot & ~st.edgeLevel);
      end
      next_st.rdata = iin_pkg::VECTOR_BASE + {4'h0, ackLine};
    end
    if (bus.wr && isAddr(bus, iin_pkg::OFF_EOI)) begin
      next_st.inService = next_st.inService & ~eoiOneHot;
    end
    // RULE7: pending request drives output
    next_st.intOut = (next_st.request & ~next_st.mask & ~next_st.inService) != 16'h0000;
    // RULE9: latch error sources
    nmiRise = st.nmiSrcSync2 & ~st.nmiStatus;
    next_st.nmiStatus = st.nmiStatus | nmiRise;
    if (bus.wr && isAddr(bus, iin_pkg::OFF_NMI_CTRL)) begin
      next_st.nmiSrcDisable = {bus.wdata[iin_pkg::NMI_SERR_EN_BIT],
                               bus.wdata[iin_pkg::NMI_CHK_EN_BIT]};
    end
    // RULE12: disable bit clears status
    next_st.nmiStatus = next_st.nmiStatus & ~next_st.nmiSrcDisable;
    if (bus.wr && isAddr(bus, iin_pkg::OFF_NMI_MASK)) begin
      next_st.nmiMask = bus.wdata[7];
    end
    // RULE13: all three enables zero
    nmiEnabled = (next_st.nmiSrcDisable == 2'b00) && !next_st.nmiMask;
    nmiActive = next_st.nmiStatus;
    // RULE10: rising edge on output
    next_st.nmiOut = nmiEnabled && (nmiActive != 2'b00);
    if (bus.wr) begin
      unique case (bus.addr)
        iin_pkg::OFF_EDGE_LEVEL_LO: next_st.edgeLevel[7:0] = bus.wdata;
        iin_pkg::OFF_EDGE_LEVEL_HI: next_st.edgeLevel[15:8] = bus.wdata;
        iin_pkg::OFF_MASK_LO: next_st.mask[7:0] = bus.wdata;
        iin_pkg::OFF_MASK_HI: next_st.mask[15:8] = bus.wdata;
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        iin_pkg::OFF_EDGE_LEVEL_LO: next_st.rdata = st.edgeLevel[7:0];
        iin_pkg::OFF_EDGE_LEVEL_HI: next_st.rdata = st.edgeLevel[15:8];
        iin_pkg::OFF_MASK_LO: next_st.rdata = st.mask[7:0];
        iin_pkg::OFF_MASK_HI: next_st.rdata = st.mask[15:8];
        iin_pkg::OFF_PENDING_LO: next_st.rdata = st.request[7:0];
        iin_pkg::OFF_PENDING_HI: next_st.rdata = st.request[15:8];
        iin_pkg::OFF_ACK: next_st.rdata = iin_pkg::VECTOR_BASE + {4'h0, ackLine};
        iin_pkg::OFF_NMI_CTRL: begin
          next_st.rdata = 8'h00;
          next_st.rdata[iin_pkg::NMI_SERR_STS_BIT] = st.nmiStatus[1];
          next_st.rdata[iin_pkg::NMI_CHK_STS_BIT] = st.nmiStatus[0];
          next_st.rdata[iin_pkg::NMI_SERR_EN_BIT] = st.nmiSrcDisable[1];
          next_st.rdata[iin_pkg::NMI_CHK_EN_BIT] = st.nmiSrcDisable[0];
        end
        iin_pkg::OFF_NMI_MASK: next_st.rdata = {st.nmiMask, 7'h00};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
      // RULE2: edge mode after reset
      st.edgeLevel <= iin_pkg::EDGE_LEVEL_RESET;
      st.mask <= iin_pkg::MASK_RESET;
      st.nmiSrcDisable <= 2'b00;
      st.nmiMask <= iin_pkg::NMI_MASK_RESET;
      // RULE14: NMI low in reset
      st.nmiOut <= 1'b0;
      st.intOut <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign intOut = st.intOut;
  assign nmiOut = st.nmiOut;
endmodule

// file: verif/iin_irq_nmi_sva.sv
// Checker for the interrupt input and NMI block.
// Assumes one clock and the strobe register port of the package.
module iin_irq_nmi_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] irqLines,
  input wire logic requestLineEightN,
  input wire logic sysErrorN,
  input wire logic channelCheckN,
  input wire iin_pkg::iin_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic intOut,
  input wire logic nmiOut
);
  logic [5:0] reqHist;
  logic [5:0] srcHist;
  logic [5:0] busHist;
  logic maskSeen;
  logic isAck;
  assign isAck = bus.rd && bus.addr == iin_pkg::OFF_ACK;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A write may release a held cause later, so bus traffic also counts as a cause.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reqHist <= 6'h00;
      srcHist <= 6'h00;
      busHist <= 6'h00;
      maskSeen <= 1'b0;
    end else begin
      reqHist <= {reqHist[4:0], |(irqLines & iin_pkg::LINES_PRESENT) | !requestLineEightN};
      srcHist <= {srcHist[4:0], !sysErrorN | !channelCheckN};
      busHist <= {busHist[4:0], bus.wr | bus.rd};
      if (bus.wr && bus.addr == iin_pkg::OFF_NMI_MASK) maskSeen <= bus.wdata[7];
    end
  end
  property p_reset; $past(reset) |-> !intOut && !nmiOut; endproperty
  a_reset: assert property (p_reset) else $error("output high after reset");
  property p_idle; !$past(bus.rd) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_vec; $past(isAck) |-> rdata inside {[8'h08:8'h17]}; endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_kbd; $past(bus.rd && bus.addr == iin_pkg::OFF_KBD_DATA) |-> rdata == 8'h00; endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard read not zero");
  property p_int; $rose(intOut) |-> |reqHist || |busHist; endproperty
  a_int: assert property (p_int) else $error("interrupt without request");
  property p_nmi; $rose(nmiOut) |-> |srcHist || |busHist; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without source");
  property p_dis; bus.wr && bus.addr == iin_pkg::OFF_NMI_CTRL && &bus.wdata[3:2] |-> ##[1:3] !nmiOut; endproperty
  a_dis: assert property (p_dis) else $error("nmi not cleared");
  property p_msk; $rose(nmiOut) |-> !(maskSeen && $past(maskSeen)); endproperty
  a_msk: assert property (p_msk) else $error("nmi while masked");
  c_int: cover property ($rose(intOut));
  c_nmi: cover property ($rose(nmiOut));
  c_ack: cover property (isAck);
endmodule
bind iin_irq_nmi iin_irq_nmi_sva chk (.clk_sys(clk_sys), .reset(reset), .irqLines(irqLines),
  .requestLineEightN(requestLineEightN), .sysErrorN(sysErrorN), .channelCheckN(channelCheckN),
  .bus(bus), .rdata(rdata), .intOut(intOut), .nmiOut(nmiOut));

// file: verif/iin_src_model.sv
// Model of the request sources and the processor acknowledge.
// Assumes the bench pulses raise and drop for one cycle.
module iin_src_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire iin_pkg::iin_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic [15:0] raise,
  input wire logic drop,
  input wire logic keep,
  output logic [15:0] irqLines,
  output logic requestLineEightN
);
  logic [15:0] held;
  logic [15:0] done;
  logic ackSeen;
  assign done = ackSeen && !keep ? 16'h0001 << (rdata - 8'h08) : 16'h0000;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      held <= 16'h0000;
      ackSeen <= 1'b0;
    end else begin
      ackSeen <= bus.rd && bus.addr == iin_pkg::OFF_ACK;
      held <= drop ? 16'h0000 : (held | raise) & ~done;
    end
  end
  assign irqLines = {held[15:9], 1'b0, held[7:0]};
  assign requestLineEightN = !held[8];
endmodule

// file: verif/iin_irq_nmi_tb.sv
// Self-checking bench for the interrupt input and NMI block.
// Assumes the source model and the bound checker.
module iin_irq_nmi_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sysErrorN = 1'b1;
  logic channelCheckN = 1'b1;
  logic drop = 1'b0;
  logic keep = 1'b0;
  logic [15:0] raise = 16'h0000;
  iin_pkg::iin_bus_t bus = '0;
  logic [15:0] irqLines;
  logic requestLineEightN;
  logic [7:0] rdata;
  logic intOut;
  logic nmiOut;
  int mismatches = 0;
  int totalChecks = 0;
  // Line number beside the vector its acknowledge must return.
  logic [11:0] rows [4] = '{12'h109, 12'h30b, 12'h810, 12'hf17};
  always #10 clk_sys = ~clk_sys;
  iin_irq_nmi uut (.clk_sys(clk_sys), .reset(reset), .irqLines(irqLines),
    .requestLineEightN(requestLineEightN), .sysErrorN(sysErrorN),
    .channelCheckN(channelCheckN), .bus(bus), .rdata(rdata), .intOut(intOut), .nmiOut(nmiOut));
  iin_src_model src (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .raise(raise),
    .drop(drop), .keep(keep), .irqLines(irqLines), .requestLineEightN(requestLineEightN));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus.rd <= 1'b0;
    @(negedge clk_sys) chk(rdata, e);
  endtask
  task automatic up(input logic [3:0] n);
    @(posedge clk_sys) raise <= 16'h0001 << n;
    @(posedge clk_sys) raise <= 16'h0000;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic dropAll();
    @(posedge clk_sys) drop <= 1'b1;
    @(posedge clk_sys) drop <= 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys) chk({6'h00, intOut, nmiOut}, 8'h00);
    rd(iin_pkg::OFF_EDGE_LEVEL_LO, 8'h00);
    rd(iin_pkg::OFF_EDGE_LEVEL_HI, 8'h00);
    wr(iin_pkg::OFF_MASK_LO, 8'h00);
    wr(iin_pkg::OFF_MASK_HI, 8'h00);
    foreach (rows[i]) begin
      up(rows[i][11:8]);
      chk({7'h00, intOut}, 8'h01);
      rd(iin_pkg::OFF_ACK, rows[i][7:0]);
      wr(iin_pkg::OFF_EOI, {4'h0, rows[i][11:8]});
    end
    up(4'h4);
    dropAll();
    rd(iin_pkg::OFF_ACK, 8'h0f);
    wr(iin_pkg::OFF_EOI, 8'h07);
    wr(iin_pkg::OFF_EDGE_LEVEL_LO, 8'h08);
    keep <= 1'b1;
    up(4'h3);
    rd(iin_pkg::OFF_ACK, 8'h0b);
    wr(iin_pkg::OFF_EOI, 8'h03);
    repeat (8) @(negedge clk_sys);
    chk({7'h00, intOut}, 8'h01);
    wr(iin_pkg::OFF_EDGE_LEVEL_LO, 8'h00);
    rd(iin_pkg::OFF_ACK, 8'h0b);
    wr(iin_pkg::OFF_EOI, 8'h03);
    repeat (8) @(negedge clk_sys);
    chk({7'h00, intOut}, 8'h00);
    keep <= 1'b0;
    dropAll();
    rd(iin_pkg::OFF_KBD_DATA, 8'h00);
    rd(8'h3f, 8'h00);
    @(posedge clk_sys) sysErrorN <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({7'h00, nmiOut}, 8'h01);
    rd(iin_pkg::OFF_NMI_CTRL, 8'h80);
    wr(iin_pkg::OFF_NMI_CTRL, 8'h0c);
    repeat (4) @(negedge clk_sys);
    chk({7'h00, nmiOut}, 8'h00);
    @(posedge clk_sys) sysErrorN <= 1'b1;
    // Let the released source pass the synchroniser before the disables are lifted.
    repeat (4) @(posedge clk_sys);
    wr(iin_pkg::OFF_NMI_CTRL, 8'h00);
    wr(iin_pkg::OFF_NMI_MASK, 8'h80);
    @(posedge clk_sys) channelCheckN <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({7'h00, nmiOut}, 8'h00);
    wr(iin_pkg::OFF_NMI_MASK, 8'h00);
    repeat (8) @(negedge clk_sys);
    chk({7'h00, nmiOut}, 8'h01);
    rd(iin_pkg::OFF_NMI_CTRL, 8'h40);
    conclude();
  end
endmodule
